/* File: src/addp_consts.vh */
// Constants for the converter output port and configuration interface.
// Assumes a single 25 MHz system clock; all pins are sampled by it.
// Function
// - Serial data in is captured on each serial clock rising edge.
// - Readback drives register bits on open-drain output, valid by falling edge.
// - Shifting happens only while chip select is low.
// - Strap low selects serial mode, high selects parallel static controls.
// - Parallel mode data-in pin selects 3.5mA or 1.75mA drive current.
// - Parallel mode serial clock pin controls sleep directly.
// - Stabilizer enabled by register bit or parallel chip select level.
// - Seven pairs carry two sample bits each per sample period.
// - Even bits are presented while output clock is low.
// - Odd bits are presented while output clock is high.
// - Data changes with both clock edges; register may delay clock phase (here it gives a pulse in the low half instead).
// - Overrange flag high for out-of-range samples, valid during clock low.
// - Overrange flag forced to zero in second half of clock cycle.
// - A conversion starts on each rising edge of the encode clock.
// - With stabilizer on, 30% to 70% duty accepted, 50% kept internally.
// - Stabilizer needs one hundred encode cycles to lock after change.
// - Overrange flag delayed by the same pipeline latency as data.
`ifndef ADDP_CONSTS_VH
`define ADDP_CONSTS_VH
// ****************************************************************
// Widths and counts
// ****************************************************************
`define ADDP_SAMPLE_W 14
`define ADDP_PAIRS 7
`define ADDP_PIPE_LAT 6
`define ADDP_LOCK_CYCLES 100
`define ADDP_NREGS 4
// ****************************************************************
// Serial frame: one read bit, seven address bits, eight data bits
// ****************************************************************
`define ADDP_FRAME_BITS 16
`define ADDP_RW_BIT 15
// ****************************************************************
// Mode register indices and field positions
// ****************************************************************
`define ADDP_REG_SLEEP 2'h0
`define ADDP_REG_CLKCFG 2'h1
`define ADDP_REG_OUTCFG 2'h2
`define ADDP_REG_FMT 2'h3
`define ADDP_SLEEP_BIT 0
`define ADDP_DCS_BIT 0
`define ADDP_PHASE_LO 1
`define ADDP_INV_BIT 3
`define ADDP_CUR_LO 0
`define ADDP_REG_RESET 8'h00
// ****************************************************************
// Drive current codes
// ****************************************************************
`define ADDP_CUR_3P5 3'h0
`define ADDP_CUR_1P75 3'h6
`endif

/* File: src/addp_fifo.v */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module addp_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire sys_clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH);
    assign out_valid = (cnt_q != 0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge sys_clk) begin
        if (rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* File: src/addp_port.v */
// Output port and configuration interface of the converter's digital side.
// Assumes encode clock and serial pins are asynchronous to sys_clk and
// much slower, so each phase lasts several sys_clk cycles.
`timescale 1ns/1ps
`include "addp_consts.vh"
module addp_port #(
    parameter SAMPLE_W = `ADDP_SAMPLE_W,
    parameter PIPE_LAT = `ADDP_PIPE_LAT,
    parameter LOCK_CYCLES = `ADDP_LOCK_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire encode_clock_pos,
    input wire encode_clock_neg,
    input wire [SAMPLE_W-1:0] core_sample,
    input wire core_over,
    input wire program_mode_strap,
    input wire cs_n,
    input wire sck,
    input wire sdi,
    output wire sdo_o,
    output wire sdo_oe,
    output reg [`ADDP_PAIRS-1:0] ddr_data_pair,
    output reg forwarded_output_clock,
    output reg overrange_flag,
    output reg sleep_en,
    output reg dcs_en,
    output reg dcs_locked,
    output reg [2:0] drive_current,
    output reg [1:0] clk_phase,
    output reg clk_invert,
    output wire sample_overflow
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg [1:0] encp_s_q;
    reg [1:0] encn_s_q;
    reg [1:0] strap_s_q;
    reg [1:0] cs_s_q;
    reg [1:0] sck_s_q;
    reg [1:0] sdi_s_q;
    reg encp_d1_q;
    reg sck_d1_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            encp_s_q <= 2'h0;
            encn_s_q <= 2'h3;
            strap_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            sck_s_q <= 2'h0;
            sdi_s_q <= 2'h0;
            encp_d1_q <= 1'b0;
            sck_d1_q <= 1'b0;
        end else begin
            encp_s_q <= {encp_s_q[0], encode_clock_pos};
            encn_s_q <= {encn_s_q[0], encode_clock_neg};
            strap_s_q <= {strap_s_q[0], program_mode_strap};
            cs_s_q <= {cs_s_q[0], cs_n};
            sck_s_q <= {sck_s_q[0], sck};
            sdi_s_q <= {sdi_s_q[0], sdi};
            encp_d1_q <= encp_s_q[1];
            sck_d1_q <= sck_s_q[1];
        end
    end
    // Strap is static, so a plain synchronised level is enough
    wire parallel_mode = strap_s_q[1];
    // Differential encode: rising when pos goes high over neg
    wire enc_level = encp_s_q[1] & ~encn_s_q[1];
    wire enc_rise = enc_level & ~encp_d1_q;
    wire sck_rise = sck_s_q[1] & ~sck_d1_q;
    wire sck_fall = ~sck_s_q[1] & sck_d1_q;
    wire cs_low = ~cs_s_q[1];
    // ****************************************************************
    // Serial configuration port
    // ****************************************************************
    reg [7:0] regs_q [0:`ADDP_NREGS-1];
    reg [4:0] bitpos_q;
    reg [15:0] shift_q;
    reg [7:0] rd_shift_q;
    reg read_q;
    reg sdo_low_q;
    integer i;
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < `ADDP_NREGS; i = i + 1) begin
                regs_q[i] <= `ADDP_REG_RESET;
            end
            bitpos_q <= 5'h00;
            shift_q <= 16'h0000;
            rd_shift_q <= 8'h00;
            read_q <= 1'b0;
            sdo_low_q <= 1'b0;
        end else if (parallel_mode || !cs_low) begin
            bitpos_q <= 5'h00;
            read_q <= 1'b0;
            sdo_low_q <= 1'b0;
        end else begin
            if (sck_rise && bitpos_q < `ADDP_FRAME_BITS) begin
                shift_q <= {shift_q[14:0], sdi_s_q[1]};
                bitpos_q <= bitpos_q + 5'h01;
                if (bitpos_q == 5'h00) begin
                    read_q <= sdi_s_q[1];
                end
                // Last address bit is still on the pin at the eighth edge
                if (bitpos_q == 5'h07) begin
                    rd_shift_q <= regs_q[{shift_q[0], sdi_s_q[1]}];
                end
                if (bitpos_q == 5'h0f && !read_q) begin
                    regs_q[shift_q[8:7]] <= {shift_q[6:0], sdi_s_q[1]};
                end
            end
            // Drive on falling edge so the host samples on the next one
            if (sck_fall && read_q && bitpos_q >= 5'h08) begin
                sdo_low_q <= ~rd_shift_q[7];
                rd_shift_q <= {rd_shift_q[6:0], 1'b0};
            end
        end
    end
    // Open drain: only ever pull low
    assign sdo_o = 1'b0;
    assign sdo_oe = sdo_low_q;
    // ****************************************************************
    // Mode controls
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            sleep_en <= 1'b0;
            dcs_en <= 1'b0;
            drive_current <= `ADDP_CUR_3P5;
            clk_phase <= 2'h0;
            clk_invert <= 1'b0;
        end else if (parallel_mode) begin
            sleep_en <= sck_s_q[1];
            dcs_en <= cs_s_q[1];
            drive_current <= sdi_s_q[1] ? `ADDP_CUR_1P75 : `ADDP_CUR_3P5;
            clk_phase <= 2'h0;
            clk_invert <= 1'b0;
        end else begin
            sleep_en <= regs_q[`ADDP_REG_SLEEP][`ADDP_SLEEP_BIT];
            dcs_en <= regs_q[`ADDP_REG_CLKCFG][`ADDP_DCS_BIT];
            drive_current <= regs_q[`ADDP_REG_OUTCFG][2:0];
            // Phase shift only works with the stabilizer on
            clk_phase <= regs_q[`ADDP_REG_CLKCFG][`ADDP_DCS_BIT] ?
                regs_q[`ADDP_REG_CLKCFG][2:1] : 2'h0;
            clk_invert <= regs_q[`ADDP_REG_CLKCFG][`ADDP_INV_BIT];
        end
    end
    // ****************************************************************
    // Stabilizer lock and encode period measurement
    // ****************************************************************
    reg [15:0] period_cnt_q;
    reg [15:0] period_q;
    reg [7:0] lock_cnt_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            period_cnt_q <= 16'h0000;
            period_q <= 16'h0000;
            lock_cnt_q <= 8'h00;
            dcs_locked <= 1'b0;
        end else begin
            if (period_cnt_q != 16'hffff) begin
                period_cnt_q <= period_cnt_q + 16'h0001;
            end
            // Stopped clock or period change restarts lock
            if (!dcs_en || period_cnt_q == 16'hffff) begin
                lock_cnt_q <= 8'h00;
                dcs_locked <= 1'b0;
            end
            if (enc_rise) begin
                period_cnt_q <= 16'h0001;
                period_q <= period_cnt_q;
                if (dcs_en) begin
                    if (period_cnt_q != period_q) begin
                        lock_cnt_q <= 8'h00;
                        dcs_locked <= 1'b0;
                    end else if (lock_cnt_q < LOCK_CYCLES) begin
                        lock_cnt_q <= lock_cnt_q + 8'h01;
                    end else begin
                        dcs_locked <= 1'b1;
                    end
                end
            end
        end
    end
    // Half period for a 50% output clock whatever the input duty
    wire [15:0] half_period = {1'b0, period_q[15:1]};
    // ****************************************************************
    // Pipeline and sample buffer
    // ****************************************************************
    reg [SAMPLE_W:0] pipe_q [0:PIPE_LAT-1];
    reg pipe_v_q;
    wire fifo_ready;
    wire fifo_valid;
    wire [SAMPLE_W:0] fifo_data;
    reg take_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < PIPE_LAT; i = i + 1) begin
                pipe_q[i] <= {(SAMPLE_W+1){1'b0}};
            end
            pipe_v_q <= 1'b0;
        end else if (enc_rise && !sleep_en) begin
            // Flag travels with data through the same stages
            pipe_q[0] <= {core_over, core_sample};
            for (i = 1; i < PIPE_LAT; i = i + 1) begin
                pipe_q[i] <= pipe_q[i-1];
            end
            pipe_v_q <= 1'b1;
        end else begin
            pipe_v_q <= 1'b0;
        end
    end
    assign sample_overflow = pipe_v_q && !fifo_ready;
    addp_fifo #(.WIDTH(SAMPLE_W + 1), .DEPTH(4), .AW(2)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(pipe_v_q),
        .in_ready(fifo_ready),
        .in_data(pipe_q[PIPE_LAT-1]),
        .out_valid(fifo_valid),
        .out_ready(take_q),
        .out_data(fifo_data)
    );
    // ****************************************************************
    // DDR output serializer
    // ****************************************************************
    reg [SAMPLE_W:0] cur_q;
    reg [15:0] phase_cnt_q;
    reg hi_half_q;
    reg clk_int_q;
    function [`ADDP_PAIRS-1:0] pick_bits;
        input [SAMPLE_W-1:0] s;
        input odd;
        integer k;
        begin
            for (k = 0; k < `ADDP_PAIRS; k = k + 1) begin
                pick_bits[k] = s[2*k + (odd ? 1 : 0)];
            end
        end
    endfunction
    always @(posedge sys_clk) begin
        if (rst) begin
            cur_q <= {(SAMPLE_W+1){1'b0}};
            phase_cnt_q <= 16'h0000;
            hi_half_q <= 1'b0;
            clk_int_q <= 1'b0;
            take_q <= 1'b0;
            ddr_data_pair <= {`ADDP_PAIRS{1'b0}};
            overrange_flag <= 1'b0;
            forwarded_output_clock <= 1'b0;
        end else begin
            take_q <= 1'b0;
            phase_cnt_q <= phase_cnt_q + 16'h0001;
            if (enc_rise) begin
                // One low half and one high half per encode period
                phase_cnt_q <= 16'h0000;
                hi_half_q <= 1'b0;
                if (fifo_valid) begin
                    cur_q <= fifo_data;
                    take_q <= 1'b1;
                end
            end else if (!hi_half_q && phase_cnt_q + 16'h0001 >= half_period) begin
                hi_half_q <= 1'b1;
            end
            clk_int_q <= hi_half_q;
            // Data moves on both clock edges when clk_phase is 0
            ddr_data_pair <= pick_bits(cur_q[SAMPLE_W-1:0], hi_half_q);
            overrange_flag <= hi_half_q ? 1'b0 : cur_q[SAMPLE_W];
            // Phase 1 or 2 gives a clock pulse from a quarter or half of the low half to its end, phase 3 none; data unaffected
            forwarded_output_clock <= clk_invert ^
                ((clk_phase == 2'h0) ? hi_half_q :
                 (phase_cnt_q >= (half_period >> (3 - clk_phase))) ^ ~hi_half_q ^ 1'b1);
        end
    end
endmodule

/* File: verification/addp_port_assertions.sv */
// Checks on the output port pins and configuration controls.
// Assumes a steady encode clock of 16 sys_clk.
`timescale 1ns/1ps
`include "addp_consts.vh"
module addp_port_assertions (
    input wire sys_clk,
    input wire rst,
    input wire program_mode_strap,
    input wire cs_n,
    input wire sck,
    input wire sdi,
    input wire sdo_o,
    input wire sdo_oe,
    input wire [`ADDP_PAIRS-1:0] ddr_data_pair,
    input wire forwarded_output_clock,
    input wire overrange_flag,
    input wire sleep_en,
    input wire dcs_en,
    input wire dcs_locked,
    input wire [2:0] drive_current,
    input wire [1:0] clk_phase,
    input wire clk_invert
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ********************
    // Sequences
    // ********************
    sequence s_cs_idle;
        (cs_n && !program_mode_strap) [*6];
    endsequence
    sequence s_no_lock;
        (!dcs_locked) [*8];
    endsequence
    // ********************
    // Checks
    // ********************
    a_of_high_zero:
        assert property (forwarded_output_clock && !clk_invert && clk_phase == 2'h0
            |-> !overrange_flag) else $error("overrange flag set in high half");
    a_data_edges:
        assert property ($changed(ddr_data_pair) && clk_phase == 2'h0
            |-> $changed(forwarded_output_clock)) else $error("data moved off clock edge");
    a_fwd_period:
        assert property ($rose(forwarded_output_clock)
            |=> (!$rose(forwarded_output_clock)) [*8]) else $error("output clock too fast");
    a_cs_ignore:
        assert property (s_cs_idle |-> $stable(drive_current) && $stable(sleep_en)
            && $stable(clk_invert) && $stable(dcs_en)) else $error("config moved without select");
    a_sdo_release:
        assert property (s_cs_idle |-> !sdo_oe) else $error("serial out driven while idle");
    a_sdo_drain:
        assert property (sdo_oe |-> !sdo_o) else $error("serial out drives high");
    a_par_sleep:
        assert property (program_mode_strap && $changed(sck)
            |-> ##[1:6] $changed(sleep_en)) else $error("sleep pin ignored");
    a_par_current:
        assert property (program_mode_strap && $changed(sdi)
            |-> ##[1:6] $changed(drive_current)) else $error("current pin ignored");
    a_par_dcs:
        assert property (program_mode_strap && $changed(cs_n)
            |-> ##[1:6] $changed(dcs_en)) else $error("stabilizer pin ignored");
    a_lock_wait:
        assert property ($rose(dcs_en) |-> s_no_lock ##[1:800] (dcs_locked || !dcs_en))
            else $error("stabilizer lock early or never");
endmodule

bind addp_port addp_port_assertions u_chk (
    .sys_clk(sys_clk), .rst(rst), .program_mode_strap(program_mode_strap),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .ddr_data_pair(ddr_data_pair), .forwarded_output_clock(forwarded_output_clock),
    .overrange_flag(overrange_flag), .sleep_en(sleep_en), .dcs_en(dcs_en),
    .dcs_locked(dcs_locked), .drive_current(drive_current), .clk_phase(clk_phase),
    .clk_invert(clk_invert)
);

/* File: verification/addp_rx_model.sv */
// Receiver model: rebuilds samples from the double-data-rate pairs.
// Assumes the output clock phases last several sys_clk cycles.
`timescale 1ns/1ps
`include "addp_consts.vh"
module addp_rx_model (
    input wire sys_clk,
    input wire rst,
    input wire [`ADDP_PAIRS-1:0] ddr_data_pair,
    input wire forwarded_output_clock,
    input wire overrange_flag,
    output reg [`ADDP_SAMPLE_W-1:0] rx_sample,
    output reg rx_over
);
    reg [`ADDP_PAIRS-1:0] even_q;
    reg [`ADDP_PAIRS-1:0] odd_q;
    reg of_q;
    reg clk_q;
    integer k;
    always @(posedge sys_clk) begin
        clk_q <= forwarded_output_clock;
        if (rst) begin
            rx_sample <= 14'h0000;
            rx_over <= 1'h0;
        end else begin
            if (!forwarded_output_clock) begin
                even_q <= ddr_data_pair;
                of_q <= overrange_flag;
            end else begin
                odd_q <= ddr_data_pair;
            end
            // Assemble on the falling edge, once both halves are in
            if (clk_q && !forwarded_output_clock) begin
                for (k = 0; k < `ADDP_PAIRS; k = k + 1) begin
                    rx_sample[2*k] <= even_q[k];
                    rx_sample[2*k+1] <= odd_q[k];
                end
                rx_over <= of_q;
            end
        end
    end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the output port and configuration pins.
// Assumes the receiver model and checker of this folder.
`timescale 1ns/1ps
`include "addp_consts.vh"
module tb;
    reg sys_clk = 1'h0;
    reg rst = 1'h1;
    reg enc = 1'h0;
    reg [3:0] enc_cnt = 4'h0;
    reg [`ADDP_SAMPLE_W-1:0] core_sample = 14'h0000;
    reg core_over = 1'h0;
    reg strap = 1'h0;
    reg cs_n = 1'h1;
    reg sck = 1'h0;
    reg sdi = 1'h0;
    reg [31:0] seed = 32'h0000_0044;
    reg [7:0] rd;
    reg [2:0] cur0;
    reg [1:0] lvl0;
    integer miscompares = 0;
    integer n_tests = 0;
    integer n_ovf = 0;
    wire ovf;
    integer i;
    integer k;
    wire sdo_o, sdo_oe, fwd_clk, of_flag, sleep_en, dcs_en, dcs_locked, clk_invert;
    wire [`ADDP_PAIRS-1:0] ddr;
    wire [2:0] drive_current;
    wire [1:0] clk_phase;
    wire [`ADDP_SAMPLE_W-1:0] rx_sample;
    wire rx_over;
    wire sdo_line = sdo_oe ? sdo_o : 1'h1; // Pull-up holds the released line high
    initial forever #20 sys_clk = ~sys_clk;
    // Encode clock of 16 sys_clk, steady so the stabilizer can lock
    always @(posedge sys_clk) begin
        enc_cnt <= enc_cnt + 4'h1;
        enc <= enc_cnt[3];
    end
    // Short lock count keeps the run brief
    addp_port #(.LOCK_CYCLES(8)) dut (
        .sys_clk(sys_clk), .rst(rst), .encode_clock_pos(enc), .encode_clock_neg(~enc),
        .core_sample(core_sample), .core_over(core_over), .program_mode_strap(strap),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .ddr_data_pair(ddr), .forwarded_output_clock(fwd_clk), .overrange_flag(of_flag),
        .sleep_en(sleep_en), .dcs_en(dcs_en), .dcs_locked(dcs_locked),
        .drive_current(drive_current), .clk_phase(clk_phase), .clk_invert(clk_invert),
        .sample_overflow(ovf)
    );
    // One push and one pop per encode period, so the buffer never fills
    always @(posedge sys_clk) begin
        if (ovf !== 1'b0 && !rst) begin
            n_ovf <= n_ovf + 1;
        end
    end
    addp_rx_model u_rx (
        .sys_clk(sys_clk), .rst(rst), .ddr_data_pair(ddr), .forwarded_output_clock(fwd_clk),
        .overrange_flag(of_flag), .rx_sample(rx_sample), .rx_over(rx_over)
    );
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input string name, input [15:0] exp, input [15:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task final_report;
        begin
            if (miscompares == 0 && n_tests > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // Shifts the first n bits of a frame, MSB first, with chip select at csv
    task spi(input [15:0] frame, input integer n, input csv);
        begin
            rd = 8'h00;
            cs_n <= csv;
            for (i = 15; i > 15 - n; i = i - 1) begin
                sdi <= frame[i];
                repeat (4) @(posedge sys_clk);
                sck <= 1'h1;
                repeat (3) @(posedge sys_clk);
                #5 rd = {rd[6:0], sdo_line};
                @(posedge sys_clk);
                sck <= 1'h0;
            end
            repeat (4) @(posedge sys_clk);
            cs_n <= 1'h1;
            repeat (8) @(posedge sys_clk);
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares = miscompares + 1;
        final_report;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        chk("reset_outs", 16'h0000, {drive_current, sleep_en, dcs_en, sdo_oe});
        // Full-scale with overrange and zero first, then random samples
        for (k = 0; k < 8; k = k + 1) begin
            seed = xs(seed);
            if (k == 0) seed[14:0] = 15'h7fff;
            if (k == 1) seed[14:0] = 15'h0000;
            core_sample <= seed[13:0];
            core_over <= seed[14];
            repeat (256) @(posedge sys_clk);
            chk("rx_sample", seed[13:0], rx_sample);
            chk("rx_over", seed[14], rx_over);
        end
        spi(16'h0206, 16, 1'h1);
        chk("cs_high", `ADDP_CUR_3P5, drive_current);
        spi(16'h0206, 5, 1'h0);
        spi(16'h0206, 16, 1'h0);
        chk("cur_write", `ADDP_CUR_1P75, drive_current);
        spi(16'h8200, 16, 1'h0);
        chk("cur_read", 16'h0006, rd);
        spi(16'h0001, 16, 1'h0);
        chk("sleep_on", 16'h0001, sleep_en);
        spi(16'h0000, 16, 1'h0);
        chk("sleep_off", 16'h0000, sleep_en);
        spi(16'h010d, 16, 1'h0);
        chk("clk_cfg", 16'h000d, {dcs_locked, clk_invert, clk_phase, dcs_en});
        for (k = 0; k < 2000 && dcs_locked !== 1'h1; k = k + 1) @(posedge sys_clk);
        chk("dcs_locked", 16'h0001, dcs_locked);
        spi(16'h8100, 16, 1'h0);
        chk("cfg_read", 16'h000d, rd);
        // Strap is only moved under reset, as a board would hold it
        rst <= 1'h1;
        strap <= 1'h1;
        cs_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (10) @(posedge sys_clk);
        cur0 = drive_current;
        lvl0 = {sleep_en, dcs_en};
        sck <= 1'h1;
        sdi <= 1'h1;
        cs_n <= 1'h1;
        repeat (10) @(posedge sys_clk);
        chk("par_current", 16'h0001, {cur0, drive_current} == {`ADDP_CUR_3P5, `ADDP_CUR_1P75}
            || {cur0, drive_current} == {`ADDP_CUR_1P75, `ADDP_CUR_3P5});
        chk("par_sleep_dcs", 16'h0003, lvl0 ^ {sleep_en, dcs_en});
        chk("no_overflow", 16'h0000, n_ovf[15:0]);
        final_report;
    end
endmodule
